// [ms_defs.svh]
// register map, field positions, reset values and result codes of the modem status block
// assumes 32-bit aligned AXI4-Lite words with byte addresses 8 bits wide
`ifndef MS_DEFS_SVH
`define MS_DEFS_SVH

`define MS_NPORTS        8
`define MS_ADDR_W        8
// per-port block: byte address = port * 16 + offset
`define MS_OFF_CTRL      4'h0
`define MS_OFF_REFMASK   4'h4
`define MS_OFF_STATUS    4'h8
`define MS_OFF_SVCEN     4'hc
`define MS_GLOBAL_BIT    7
// board-wide registers
`define MS_OFF_JUMP      8'h80
`define MS_OFF_IRQ_STS   8'h84
`define MS_OFF_IRQ_MASK  8'h88
`define MS_OFF_BOARD     8'h8c
// field positions
`define MS_MASK_LSB      8
`define MS_DEV_BIT       8
`define MS_ERR_BIT       9
`define MS_JUMP_PORT_LSB 4
// reset values
`define MS_CFG_RST       17'h00000
`define MS_IRQ_RST       8'h00
// service jump result codes
`define MS_CODE_STATUS   2'h2
`define MS_CODE_RX       2'h0
`define MS_CODE_TX       2'h1
`define MS_CODE_NONE     2'h3
// bus responses
`define MS_RESP_OKAY     2'h0
`define MS_RESP_SLVERR   2'h2

`endif

// [ms_pkg.sv]
// types shared by the modem status block and its helpers
// assumes nothing beyond the constants header
package ms_pkg;
  typedef struct packed {
    logic sca;
    logic ch;
    logic cd;
    logic ca;
  } modem_out_t;

  typedef struct packed {
    logic scf;
    logic cf;
    logic ce;
    logic cc;
    logic cb;
  } modem_in_t;

  typedef struct packed {
    logic status;
    logic tx;
    logic rx;
  } svc_en_t;

  typedef struct packed {
    modem_out_t out;
    modem_in_t  ref_lvl;
    modem_in_t  mask;
    svc_en_t    en;
  } port_cfg_t;

  typedef enum logic [0:0] {WR_COLLECT = 1'b0, WR_RESP = 1'b1} wr_state_t;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_t;
endpackage

// [sync2.sv]
// two-flop synchroniser for a bundle of unrelated level inputs
// assumes each bit is an independent level; no word coherence
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  always_comb
  begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule // sync2

// [svc_jump.sv]
// service jump encoder: one registered code and port for the whole board
// assumes request vectors are already gated by their enables
`timescale 1ns/1ps
`include "ms_defs.svh"
module svc_jump (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // per-port requests
  input  wire logic [7:0] status_req,
  input  wire logic [7:0] rx_req,
  input  wire logic [7:0] tx_req,
  // result
  output logic      [1:0] code,
  output logic      [2:0] port
);
  logic [1:0] next_code;
  logic [2:0] next_port;

  // lowest numbered requesting port wins within a class
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (v[i])
        idx = i[2:0];
    return idx;
  endfunction

  always_comb
  begin
    next_code = `MS_CODE_NONE;
    next_port = 3'h0;
    if (|status_req)
    begin
      next_code = `MS_CODE_STATUS;
      next_port = first_set(status_req);
    end
    else if (|rx_req)
    begin
      next_code = `MS_CODE_RX;
      next_port = first_set(rx_req);
    end
    else if (|tx_req)
    begin
      next_code = `MS_CODE_TX;
      next_port = first_set(tx_req);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      code <= `MS_CODE_NONE;
      port <= 3'h0;
    end
    else
    begin
      code <= next_code;
      port <= next_port;
    end
  end
endmodule // svc_jump

// [modem_status_service.sv]
// modem control, modem status monitor and service jump for eight serial ports
// assumes uart flags on aclk, modem inputs and extension strap asynchronous
//
// Behaviour
// - Each port drives CA, CD, CH and SCA from the bits software writes to its modem control register.
// - Each port holds a reference level and a mask bit per input line, loaded by one register write.
// - Reading a port's status register returns the current levels of CB, CC, CE, CF and SCF.
// - An unmasked input that differs from its reference raises the status service condition of that port.
// - Deviation is detected both for a line low against a high reference and high against a low one.
// - Each status bit follows only its own input line.
// - CH and CE exist only when the extension is present; otherwise CH stays low and CE reads low.
// - Serial data traffic never changes modem status bits or raises the status condition.
// - With several conditions pending only the highest priority one is reported.
// - Result codes from highest priority: 2 status, 0 receive pending, 1 transmit loadable, 3 none.
// - Transmit empty, receive full and modem change are enabled independently per port.
// - Clearing a port's mask bits removes its modem status condition so lower ones show.
// - Disabling the receive condition suppresses code 0 even with a character waiting.
// - Disabling the transmit condition suppresses code 1; with all disabled the code is 3 unless a receiver overrun or parity error is pending.
// - Receiver overrun or parity error also raises the status condition.
`timescale 1ns/1ps
`include "ms_defs.svh"
module modem_status_service (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]                    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  // axi4-lite write response
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // axi4-lite read
  input  wire logic [7:0]                    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // modem circuits
  input  wire ms_pkg::modem_in_t [7:0]       modem_in,
  output ms_pkg::modem_out_t [7:0]           modem_out,
  input  wire logic                          ext_present,
  // uart flags per port
  input  wire logic [7:0]                    rx_full,
  input  wire logic [7:0]                    tx_empty,
  input  wire logic [7:0]                    rx_overrun,
  input  wire logic [7:0]                    rx_parity_err,
  // interrupt
  output logic                               irq
);
  ms_pkg::port_cfg_t [7:0] cfg;
  ms_pkg::port_cfg_t [7:0] next_cfg;
  ms_pkg::modem_in_t [7:0] sync_in;
  ms_pkg::modem_in_t [7:0] eff_in;
  ms_pkg::modem_in_t       avail;
  ms_pkg::modem_out_t [7:0] next_modem_out;
  logic                    ext_s;
  logic [7:0]              dev;
  logic [7:0]              status_req;
  logic [7:0]              status_req_q;
  logic [7:0]              rx_req;
  logic [7:0]              tx_req;
  logic [1:0]              jump_code;
  logic [2:0]              jump_port;
  logic [7:0]              irq_sts;
  logic [7:0]              irq_mask;
  logic [7:0]              next_irq_sts;
  logic [7:0]              next_irq_mask;
  logic                    next_irq;
  // write channel state
  ms_pkg::wr_state_t       wr_state;
  ms_pkg::wr_state_t       next_wr_state;
  logic                    aw_got;
  logic                    w_got;
  logic [7:0]              addr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    next_aw_got;
  logic                    next_w_got;
  logic [7:0]              next_addr_q;
  logic [31:0]             next_wdata_q;
  logic [3:0]              next_wstrb_q;
  logic                    next_awready;
  logic                    next_wready;
  logic                    next_bvalid;
  logic [1:0]              next_bresp;
  logic                    wr_fire;
  // read channel state
  ms_pkg::rd_state_t       rd_state;
  ms_pkg::rd_state_t       next_rd_state;
  logic                    next_arready;
  logic                    next_rvalid;
  logic [31:0]             next_rdata;
  logic [1:0]              next_rresp;

  // modem inputs and strap are asynchronous to aclk
  sync2 #(
    .W (41)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({ext_present, modem_in}),
    .dout    ({ext_s, sync_in})
  );

  svc_jump u_jump (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .status_req (status_req),
    .rx_req     (rx_req),
    .tx_req     (tx_req),
    .code       (jump_code),
    .port       (jump_port)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[b*8 +: 8] = nw[b*8 +: 8];
    return res;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    logic ok;
    ok = !a[`MS_GLOBAL_BIT] ||
         (a[7:2] == `MS_OFF_JUMP >> 2) || (a[7:2] == `MS_OFF_IRQ_STS >> 2) ||
         (a[7:2] == `MS_OFF_IRQ_MASK >> 2) || (a[7:2] == `MS_OFF_BOARD >> 2);
    return ok;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] v;
    logic [2:0]  p;
    v = 32'h0;
    p = a[6:4];
    if (!a[`MS_GLOBAL_BIT])
    begin
      case ({a[3:2], 2'b00})
        `MS_OFF_CTRL:    v[3:0] = cfg[p].out;
        `MS_OFF_REFMASK: v = {19'h0, cfg[p].mask, 3'h0, cfg[p].ref_lvl};
        `MS_OFF_STATUS:
        begin
          v[4:0] = eff_in[p];
          v[`MS_DEV_BIT] = dev[p];
          v[`MS_ERR_BIT] = rx_overrun[p] | rx_parity_err[p];
        end
        `MS_OFF_SVCEN:   v[2:0] = cfg[p].en;
        default:         v = 32'h0;
      endcase
    end
    else
    begin
      case ({a[7:2], 2'b00})
        `MS_OFF_JUMP:     v = {25'h0, jump_port, 2'h0, jump_code};
        `MS_OFF_IRQ_STS:  v[7:0] = irq_sts;
        `MS_OFF_IRQ_MASK: v[7:0] = irq_mask;
        `MS_OFF_BOARD:    v[0] = ext_s;
        default:          v = 32'h0;
      endcase
    end
    return v;
  endfunction

  // service conditions; only modem pins and uart flags reach them, never data
  always_comb
  begin
    avail = '1;
    avail.ce = ext_s;
    for (int p = 0; p < 8; p++)
    begin
      eff_in[p] = sync_in[p] & avail;
      dev[p] = |((eff_in[p] ^ cfg[p].ref_lvl) & cfg[p].mask);
      status_req[p] = (cfg[p].en.status & dev[p])
                    | rx_overrun[p] | rx_parity_err[p];
      rx_req[p] = cfg[p].en.rx & rx_full[p];
      tx_req[p] = cfg[p].en.tx & tx_empty[p];
      next_modem_out[p] = cfg[p].out;
      next_modem_out[p].ch = cfg[p].out.ch & ext_s;
    end
  end

  // write channel; address and data taken in either order, write done when both held
  always_comb
  begin
    logic [31:0] w;
    logic [2:0]  p;
    w = 32'h0;
    p = addr_q[6:4];
    next_wr_state = wr_state;
    next_aw_got   = aw_got;
    next_w_got    = w_got;
    next_addr_q   = addr_q;
    next_wdata_q  = wdata_q;
    next_wstrb_q  = wstrb_q;
    next_awready  = awready;
    next_wready   = wready;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_cfg      = cfg;
    next_irq_mask = irq_mask;
    next_irq_sts  = irq_sts;
    wr_fire       = 1'b0;
    case (wr_state)
      ms_pkg::WR_COLLECT:
      begin
        if (awvalid && awready)
        begin
          next_aw_got  = 1'b1;
          next_addr_q  = awaddr;
          next_awready = 1'b0;
        end
        if (wvalid && wready)
        begin
          next_w_got   = 1'b1;
          next_wdata_q = wdata;
          next_wstrb_q = wstrb;
          next_wready  = 1'b0;
        end
        if (aw_got && w_got)
        begin
          wr_fire       = 1'b1;
          next_bvalid   = 1'b1;
          next_bresp    = addr_ok(addr_q) ? `MS_RESP_OKAY : `MS_RESP_SLVERR;
          next_wr_state = ms_pkg::WR_RESP;
        end
      end
      ms_pkg::WR_RESP:
      begin
        if (bready)
        begin
          next_bvalid   = 1'b0;
          next_aw_got   = 1'b0;
          next_w_got    = 1'b0;
          next_awready  = 1'b1;
          next_wready   = 1'b1;
          next_wr_state = ms_pkg::WR_COLLECT;
        end
      end
      default:
        next_wr_state = ms_pkg::WR_COLLECT;
    endcase
    if (wr_fire && !addr_q[`MS_GLOBAL_BIT])
    begin
      case ({addr_q[3:2], 2'b00})
        `MS_OFF_CTRL:
        begin
          w = merge({28'h0, cfg[p].out}, wdata_q, wstrb_q);
          next_cfg[p].out = w[3:0];
        end
        `MS_OFF_REFMASK:
        begin
          w = merge({19'h0, cfg[p].mask, 3'h0, cfg[p].ref_lvl}, wdata_q, wstrb_q);
          next_cfg[p].ref_lvl = w[4:0];
          next_cfg[p].mask = w[`MS_MASK_LSB +: 5];
        end
        `MS_OFF_SVCEN:
        begin
          w = merge({29'h0, cfg[p].en}, wdata_q, wstrb_q);
          next_cfg[p].en = w[2:0];
        end
        default:
          w = 32'h0;
      endcase
    end
    if (wr_fire && ({addr_q[7:2], 2'b00} == `MS_OFF_IRQ_MASK) && wstrb_q[0])
      next_irq_mask = wdata_q[7:0];
    if (wr_fire && ({addr_q[7:2], 2'b00} == `MS_OFF_IRQ_STS) && wstrb_q[0])
      next_irq_sts = irq_sts & ~wdata_q[7:0];
    // a new condition in the clearing cycle survives the clear
    next_irq_sts = next_irq_sts | (status_req & ~status_req_q);
    next_irq = |(irq_sts & irq_mask);
  end

  // read channel; data sampled at the address handshake
  always_comb
  begin
    next_rd_state = rd_state;
    next_arready  = arready;
    next_rvalid   = rvalid;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      ms_pkg::RD_IDLE:
      begin
        if (arvalid && arready)
        begin
          next_arready  = 1'b0;
          next_rvalid   = 1'b1;
          next_rdata    = read_word(araddr);
          next_rresp    = addr_ok(araddr) ? `MS_RESP_OKAY : `MS_RESP_SLVERR;
          next_rd_state = ms_pkg::RD_DATA;
        end
      end
      ms_pkg::RD_DATA:
      begin
        if (rready)
        begin
          next_rvalid   = 1'b0;
          next_arready  = 1'b1;
          next_rd_state = ms_pkg::RD_IDLE;
        end
      end
      default:
        next_rd_state = ms_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg          <= {8{`MS_CFG_RST}};
      modem_out    <= '0;
      status_req_q <= 8'h00;
      irq_sts      <= `MS_IRQ_RST;
      irq_mask     <= `MS_IRQ_RST;
      irq          <= 1'b0;
      wr_state     <= ms_pkg::WR_COLLECT;
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      addr_q       <= 8'h00;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      awready      <= 1'b1;
      wready       <= 1'b1;
      bvalid       <= 1'b0;
      bresp        <= `MS_RESP_OKAY;
      rd_state     <= ms_pkg::RD_IDLE;
      arready      <= 1'b1;
      rvalid       <= 1'b0;
      rdata        <= 32'h0;
      rresp        <= `MS_RESP_OKAY;
    end
    else
    begin
      cfg          <= next_cfg;
      modem_out    <= next_modem_out;
      status_req_q <= status_req;
      irq_sts      <= next_irq_sts;
      irq_mask     <= next_irq_mask;
      irq          <= next_irq;
      wr_state     <= next_wr_state;
      aw_got       <= next_aw_got;
      w_got        <= next_w_got;
      addr_q       <= next_addr_q;
      wdata_q      <= next_wdata_q;
      wstrb_q      <= next_wstrb_q;
      awready      <= next_awready;
      wready       <= next_wready;
      bvalid       <= next_bvalid;
      bresp        <= next_bresp;
      rd_state     <= next_rd_state;
      arready      <= next_arready;
      rvalid       <= next_rvalid;
      rdata        <= next_rdata;
      rresp        <= next_rresp;
    end
  end

  property p_prio_rx;
    @(posedge aclk) disable iff (!aresetn) (|rx_req && !(|status_req)) |=> (jump_code == `MS_CODE_RX);
  endproperty
  a_prio_rx: assert property (p_prio_rx) else $error("receive code not reported");

  property p_prio_tx;
    @(posedge aclk) disable iff (!aresetn)
      (|tx_req && !(|rx_req) && !(|status_req)) |=> (jump_code == `MS_CODE_TX);
  endproperty
  a_prio_tx: assert property (p_prio_tx) else $error("transmit code not reported");

  property p_none;
    @(posedge aclk) disable iff (!aresetn) !(|{status_req, rx_req, tx_req}) |=> (jump_code == `MS_CODE_NONE);
  endproperty
  a_none: assert property (p_none) else $error("idle code not three");

  for (genvar g = 0; g < 8; g++)
  begin : g_chk
    property p_ctrl;
      @(posedge aclk) disable iff (!aresetn)
        (wr_fire && addr_q == {1'b0, 3'(g), `MS_OFF_CTRL} && wstrb_q[0]) |=> ##1
        (modem_out[g].ca == $past(wdata_q[0], 2) && modem_out[g].sca == $past(wdata_q[3], 2));
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("modem output not following write");

    property p_refmask;
      @(posedge aclk) disable iff (!aresetn)
        (wr_fire && addr_q == {1'b0, 3'(g), `MS_OFF_REFMASK} && wstrb_q[1:0] == 2'b11) |=>
        (cfg[g].ref_lvl == $past(wdata_q[4:0]) && cfg[g].mask == $past(wdata_q[12:8]));
    endproperty
    a_refmask: assert property (p_refmask) else $error("reference or mask not loaded");

    property p_jump_status;
      @(posedge aclk) disable iff (!aresetn) status_req[g] |=> (jump_code == `MS_CODE_STATUS);
    endproperty
    a_jump_status: assert property (p_jump_status) else $error("status code not reported");

    property p_mask_clear;
      @(posedge aclk) disable iff (!aresetn)
        (cfg[g].mask == 5'h00 && !rx_overrun[g] && !rx_parity_err[g]) |-> !status_req[g];
    endproperty
    a_mask_clear: assert property (p_mask_clear) else $error("masked line raised status");

    property p_status_read;
      @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && araddr == {1'b0, 3'(g), `MS_OFF_STATUS}) |=>
        (rvalid && rdata[4:0] == $past(eff_in[g]));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read not current levels");

    property p_ext;
      @(posedge aclk) disable iff (!aresetn) (!ext_s && !$past(ext_s)) |-> (!modem_out[g].ch && !eff_in[g].ce);
    endproperty
    a_ext: assert property (p_ext) else $error("extension lines active without extension");

    property p_traffic;
      @(posedge aclk) disable iff (!aresetn)
        (!rx_overrun[g] && !rx_parity_err[g] && !$past(rx_overrun[g]) && !$past(rx_parity_err[g])
         && $stable(eff_in[g]) && $stable(cfg[g])) |-> $stable(status_req[g]);
    endproperty
    a_traffic: assert property (p_traffic) else $error("status changed without modem change");
  end
endmodule // modem_status_service

// [modem_loop.sv]
// loopback plug model: each port's modem outputs wired back to its modem inputs
// assumes the extension strap says whether the ce pin is wired at all
`timescale 1ns/1ps
module modem_loop (
  // plug side
  input  wire ms_pkg::modem_out_t [7:0] mo,
  input  wire logic                     ext,
  // board side
  output ms_pkg::modem_in_t [7:0]       mi
);
  always_comb
  begin
    for (int p = 0; p < 8; p++)
    begin
      // unwired ce shows the opposite level so a leak cannot hide
      mi[p] = '{scf: mo[p].sca, cf: mo[p].ca, ce: ext ? mo[p].ch : ~mo[p].ch, cc: mo[p].cd, cb: mo[p].ca};
    end
  end
endmodule // modem_loop

// [modem_status_service_priority_tb.sv]
// self-checking bench: bus master, loopback plug and queued result checks
// assumes the register map header and a 100 MHz aclk
`timescale 1ns/1ps
`include "ms_defs.svh"
module modem_status_service_priority_tb;
  logic                     aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_present;
  logic                     awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]               awaddr, araddr, rx_full, tx_empty, rx_overrun, rx_parity_err;
  logic [31:0]              wdata, rdata, rng;
  logic [3:0]               wstrb, c0, c1;
  logic [2:0]               p, q;
  logic [1:0]               bresp, rresp;
  logic [67:0]              rq[$];
  logic [1:0]               wq[$];
  int                       fail_count, checks_done;
  ms_pkg::modem_in_t [7:0]  modem_in;
  ms_pkg::modem_out_t [7:0] modem_out;
  localparam logic [33:0]   NPORT = 34'h3ffffff8f;

  modem_status_service dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .modem_in, .modem_out, .ext_present, .rx_full, .tx_empty, .rx_overrun, .rx_parity_err, .irq);
  modem_loop plug (.mo(modem_out), .ext(ext_present), .mi(modem_in));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // expected response follows the address: the top of the map is unmapped
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wq.push_back(a >= 8'h90 ? `MS_RESP_SLVERR : `MS_RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) bready <= 1'b0;
    end while ((awvalid || wvalid || bready) && n < 40);
    if (n >= 40)
    begin
      fail_count++;
      close_out;
    end
  endtask

  task rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] care);
    int n;
    n = 0;
    rq.push_back({care, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) rready <= 1'b0;
    end while ((arvalid || rready) && n < 40);
    if (n >= 40)
    begin
      fail_count++;
      close_out;
    end
  endtask

  function automatic logic [33:0] st(input logic [3:0] c, input logic [4:0] rf, mk, input logic e);
    logic [4:0] l;
    l = {c[3], c[0], c[2] & e, c[1], c[0]};
    return {2'b0, 23'h0, |((l ^ rf) & mk), 3'h0, l};
  endfunction

  function automatic logic [33:0] jp(input logic [1:0] code, input logic [2:0] port);
    return {2'b0, 25'h0, port, 2'b0, code};
  endfunction

  function automatic logic [31:0] nxt(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // results come back in request order, one note per answer
  always @(posedge aclk)
  begin
    logic [67:0] nt;
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, wq.pop_front()});
    if (rvalid && rready)
    begin
      nt = rq.pop_front();
      chk({rresp, rdata} & nt[67:34], nt[33:0] & nt[67:34]);
    end
  end

  initial
  begin
    repeat (100000) @(posedge aclk);
    fail_count++;
    close_out;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {rx_full, tx_empty, rx_overrun, rx_parity_err} = '0;
    ext_present = 1'b1;
    wstrb = 4'hf;
    rng = 32'h1b11;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, 34'h0, '1);
    rd(`MS_OFF_JUMP, jp(`MS_CODE_NONE, 3'h0), NPORT);
    for (int r = 0; r < 2; r++)
      for (int b = 0; b < 4; b++)
      begin
        rng = nxt(rng);
        p = rng[2:0];
        c0 = r ? 4'hf : 4'h0;
        c1 = c0 ^ (4'h1 << b);
        wr({p, `MS_OFF_REFMASK}, {19'h0, 5'h1f, 3'h0, r ? 5'h1f : 5'h0});
        wr({p, `MS_OFF_SVCEN}, 32'h4);
        wr({p, `MS_OFF_CTRL}, {28'h0, c1});
        repeat (6) @(posedge aclk);
        chk(modem_out[p], c1);
        rd({p, `MS_OFF_STATUS}, st(c1, r ? 5'h1f : 5'h0, 5'h1f, 1'b1), '1);
        rd(`MS_OFF_JUMP, jp(`MS_CODE_STATUS, p), '1);
        wr({p, `MS_OFF_CTRL}, {28'h0, c0});
        repeat (6) @(posedge aclk);
        rd(`MS_OFF_JUMP, jp(`MS_CODE_NONE, 3'h0), NPORT);
      end
    q = rng[6:4];
    // other ports have their status enable cleared, so without the strap only q may report status
    for (int i = 0; i < 8; i++)
      wr({i[2:0], `MS_OFF_SVCEN}, {29'h0, i[2:0] == q, 2'b00});
    ext_present <= 1'b0;
    wr({q, `MS_OFF_REFMASK}, 32'h1f);
    wr({q, `MS_OFF_CTRL}, 32'hf);
    repeat (6) @(posedge aclk);
    chk(modem_out[q], 4'hb);
    rd({q, `MS_OFF_STATUS}, st(4'hf, 5'h1f, 5'h0, 1'b0), '1);
    rd(`MS_OFF_BOARD, 34'h0, '1);
    rd(`MS_OFF_JUMP, jp(`MS_CODE_NONE, 3'h0), NPORT);
    ext_present <= 1'b1;
    // clear stale events first; a clear after the rise would wipe the new one
    wr(`MS_OFF_IRQ_STS, 32'hff);
    wr(`MS_OFF_IRQ_MASK, 32'hff);
    wr({q, `MS_OFF_CTRL}, 32'h0);
    wr({q, `MS_OFF_REFMASK}, 32'h021f);
    wr({q, `MS_OFF_SVCEN}, 32'h7);
    rx_full[q] <= 1'b1;
    tx_empty[q] <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(`MS_OFF_JUMP, jp(`MS_CODE_STATUS, q), '1);
    chk(irq, 1'b1);
    rd(`MS_OFF_IRQ_STS, 34'h1 << q, '1);
    wr(`MS_OFF_IRQ_STS, 32'h1 << q);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    wr({q, `MS_OFF_REFMASK}, 32'h1f);
    repeat (4) @(posedge aclk);
    rd(`MS_OFF_JUMP, jp(`MS_CODE_RX, q), '1);
    wr({q, `MS_OFF_SVCEN}, 32'h2);
    repeat (4) @(posedge aclk);
    rd(`MS_OFF_JUMP, jp(`MS_CODE_TX, q), '1);
    wr({q, `MS_OFF_SVCEN}, 32'h0);
    repeat (4) @(posedge aclk);
    rd(`MS_OFF_JUMP, jp(`MS_CODE_NONE, 3'h0), NPORT);
    for (int e = 0; e < 2; e++)
    begin
      rx_overrun[q] <= e[0];
      rx_parity_err[q] <= ~e[0];
      repeat (4) @(posedge aclk);
      rd(`MS_OFF_JUMP, jp(`MS_CODE_STATUS, q), '1);
    end
    {rx_overrun, rx_parity_err} <= '0;
    wr({q, `MS_OFF_REFMASK}, 32'h1f00);
    wr({q, `MS_OFF_SVCEN}, 32'h4);
    // uart flags churn while lines stay put
    repeat (64)
    begin
      @(posedge aclk);
      rng = nxt(rng);
      rx_full <= rng[7:0];
      tx_empty <= rng[15:8];
    end
    {rx_full, tx_empty} <= '0;
    repeat (4) @(posedge aclk);
    rd({q, `MS_OFF_STATUS}, 34'h0, '1);
    rd(`MS_OFF_JUMP, jp(`MS_CODE_NONE, 3'h0), NPORT);
    wr(8'h90, 32'hffff);
    rd(8'h94, {`MS_RESP_SLVERR, 32'h0}, '1);
    repeat (2) @(posedge aclk);
    close_out;
  end
endmodule // modem_status_service_priority_tb
